// ### hw/ppc_pkg.sv
// package: register map, field positions, resets and timing for pin/power control
package ppc_pkg;
	// register indices
	localparam logic [2:0] IDX_FEATURE = 3'h0;
	localparam logic [2:0] IDX_POWER   = 3'h2;
	localparam logic [2:0] IDX_PINFUNC = 3'h3;
	localparam logic [2:0] IDX_PRINTER = 3'h4;
	localparam logic [2:0] IDX_STATUS  = 3'h5;
	// pin function fields
	localparam int PF_RATE   = 0;
	localparam int PF_DMA    = 1;
	localparam int PF_MUX    = 2;
	localparam int PF_FLOAT  = 3;
	localparam int PF_SWAP   = 4;
	localparam int PF_ZWS    = 5;
	localparam int PF_PDSEL  = 6;
	localparam int PF_RECSEL = 7;
	// printer control fields
	localparam int PR_EN    = 0;
	localparam int PR_VER   = 1;
	localparam int PR_LEVEL = 4;
	localparam logic [7:0] PR_WMASK = 8'h13;
	// power/test fields
	localparam int PT_PD    = 0;
	localparam int PT_XTAL  = 1;
	localparam int PT_CSSEL = 2;
	// feature enable fields
	localparam int FE_UART1 = 1;
	localparam int FE_UART2 = 2;
	localparam int FE_FLOP  = 3;
	localparam int FE_ENC   = 4;
	// reset values
	localparam logic [7:0] PINFUNC_RST = 8'h00;
	localparam logic [7:0] PRINTER_RST = 8'h00;
	localparam logic [7:0] POWER_RST   = 8'h00;
	localparam logic [7:0] FEATURE_RST = 8'h0E;
	localparam logic [4:0] STRAP_ALL   = 5'h1F;
	// crystal stabilisation
	localparam int CLK_HZ      = 10000000;
	localparam int XTAL_MS     = 8;
	localparam int XTAL_CYCLES = CLK_HZ / 1000 * XTAL_MS;

	// register bus request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ppc_bus_t;

	// floppy drive controls from the disk controller
	typedef struct packed {
		logic sel0;
		logic sel1;
		logic mot0;
		logic mot1;
	} ppc_drive_t;

	// function clock enables
	typedef struct packed {
		logic uart1;
		logic uart2;
		logic flop;
	} ppc_clken_t;
endpackage

// ### hw/ppc_top.sv
// pin option, printer option and power control block
//
// Local design decision: strobed register access.
module ppc_top #(
	parameter int XTAL_CYCLES = ppc_pkg::XTAL_CYCLES
) (
	// clock, reset, enable
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               ce,
	// register port
	input  wire ppc_pkg::ppc_bus_t  bus,
	output logic [7:0]              rdata,
	// straps sampled on the first enabled edge after reset
	input  wire logic               valid_strap_input,
	input  wire logic [4:0]         configuration_straps,
	// media sense / rate pins
	input  wire logic [1:0]         media_sense_inputs,
	input  wire logic [1:0]         rate_in,
	output logic [1:0]              rate_select_outputs,
	output logic [1:0]              rate_select_oe,
	output logic [1:0]              media_sense_value,
	// disk dma
	input  wire logic               drive_mode_strap,
	output logic                    drive_mode_value,
	output logic                    disk_dma_enable,
	// printer/floppy mux
	output logic                    printer_floppy_mux,
	output logic                    mux_pins_oe,
	output logic                    mux_pullup_en,
	// drive controls
	input  wire ppc_pkg::ppc_drive_t drv_in,
	output ppc_pkg::ppc_drive_t      drv_pins,
	// shared zero-wait / power-down / chip-select pin
	input  wire logic               epp_short_ok,
	input  wire logic               chip_sel_in,
	input  wire logic               power_down_pin,
	output logic                    zero_wait_output,
	output logic                    zero_wait_oe,
	output logic                    chip_select_output,
	output logic                    chip_select_oe,
	// ready / recording strap pin
	input  wire logic               epp_wait,
	input  wire logic               recording_mode_strap,
	output logic                    chrdy_out,
	output logic                    chrdy_oe,
	output logic                    recording_mode_value,
	// enhanced printer port controls
	input  wire logic               epp_access,
	output logic                    epp_access_ok,
	output logic                    epp_version_19,
	output logic                    epp_level_irq,
	// floppy low-power requests
	input  wire logic               flop_lowpwr,
	input  wire logic               flop_recover,
	input  wire logic               rqm_core,
	output logic                    request_for_master,
	// clocks and crystal
	output ppc_pkg::ppc_clken_t     clk_en,
	output logic                    xtal_run
);
	// refuse a settle count below one cycle
	if (XTAL_CYCLES < 1) begin : g_bad_settle
		$error("XTAL_CYCLES must be at least one");
	end

	// configuration registers
	logic [7:0]  pinfunc_q;
	logic [7:0]  printer_q;
	logic [7:0]  power_q;
	logic [7:0]  feature_q;
	// strap capture on the first enabled edge
	logic        strap_done_q;
	logic        xtal_stop_strap_q;
	// crystal settle timer and floppy low-power latch
	logic [31:0] stab_q;
	logic        flop_low_q;
	logic        xtal_low_q;
	// read path
	logic [7:0]  rdata_d;
	logic [7:0]  rdata_q;

	// write strobe aimed at one register index
	function automatic logic reg_write(
		input ppc_pkg::ppc_bus_t b,
		input logic [2:0]        idx
	);
		return b.wr && (b.addr == idx);
	endfunction

	// register decode
	wire wr_pf  = reg_write(bus, ppc_pkg::IDX_PINFUNC);
	wire wr_pr  = reg_write(bus, ppc_pkg::IDX_PRINTER);
	wire wr_pt  = reg_write(bus, ppc_pkg::IDX_POWER);
	wire wr_fe  = reg_write(bus, ppc_pkg::IDX_FEATURE);

	// shared pin role decode
	wire pd_role  = pinfunc_q[ppc_pkg::PF_PDSEL]
		&& !power_q[ppc_pkg::PT_CSSEL];
	wire cs_role  = pinfunc_q[ppc_pkg::PF_PDSEL]
		&& power_q[ppc_pkg::PT_CSSEL];

	// power-down pin is active low, only in its role
	wire pd_pin   = pd_role && !power_down_pin;           // active low
	wire pd_all   = power_q[ppc_pkg::PT_PD] || pd_pin;

	// crystal stop sources and settle status
	wire xtal_sel = power_q[ppc_pkg::PT_XTAL];
	wire xtal_off = (pd_all && xtal_sel) || xtal_stop_strap_q
		|| xtal_low_q;
	wire stable   = stab_q == 32'h0;

	// uart clocks: enabled and not powered down
	wire u1_on = feature_q[ppc_pkg::FE_UART1] && !pd_all;
	wire u2_on = feature_q[ppc_pkg::FE_UART2] && !pd_all;

	// floppy clock: also off in its own low power
	wire fl_on = feature_q[ppc_pkg::FE_FLOP] && !pd_all
		&& !flop_low_q;

	// drive exchange
	wire swap = pinfunc_q[ppc_pkg::PF_SWAP];
	// swapped pins, encoded drive mode excluded by software
	ppc_pkg::ppc_drive_t drv_d;
	assign drv_d = swap ? {drv_in.sel1, drv_in.sel0, drv_in.mot1,
		drv_in.mot0} : drv_in;

	// read mux, unmapped reads as zero
	always_comb begin
		case (bus.addr)
			ppc_pkg::IDX_FEATURE: rdata_d = feature_q;
			ppc_pkg::IDX_POWER:   rdata_d = power_q;
			ppc_pkg::IDX_PINFUNC: rdata_d = pinfunc_q;
			ppc_pkg::IDX_PRINTER: rdata_d = printer_q;
			// status: settle flag and function clocks
			ppc_pkg::IDX_STATUS:  rdata_d = {4'h0, stable,
				clk_en.flop, clk_en.uart2, clk_en.uart1};
			default:              rdata_d = 8'h00;
		endcase
	end

	// configuration register processes
	// strap capture, once on the first enabled edge after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strap_done_q <= 1'b0;
		end else if (ce) begin
			strap_done_q <= 1'b1;
		end
	end

	// pin function register, bit 0 loaded from its strap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinfunc_q <= ppc_pkg::PINFUNC_RST;
		end else if (ce) begin
			if (!strap_done_q)
				pinfunc_q[ppc_pkg::PF_RATE] <= valid_strap_input;
			else if (wr_pf)
				pinfunc_q <= bus.wdata;
		end
	end

	// printer control, reserved bits held at zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			printer_q <= ppc_pkg::PRINTER_RST;
		end else if (ce && wr_pr) begin
			printer_q <= bus.wdata & ppc_pkg::PR_WMASK;
		end
	end

	// power/test and feature enable registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_q   <= ppc_pkg::POWER_RST;
			feature_q <= ppc_pkg::FEATURE_RST;
		end else if (ce) begin
			if (wr_pt)
				power_q <= bus.wdata;
			if (wr_fe)
				feature_q <= bus.wdata;
		end
	end

	// all-straps-high crystal stop, cleared by a power-up write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			xtal_stop_strap_q <= 1'b0;
		end else if (ce) begin
			if (wr_pt && !bus.wdata[ppc_pkg::PT_PD])
				xtal_stop_strap_q <= 1'b0;
			else if (!strap_done_q)
				xtal_stop_strap_q <= configuration_straps
					== ppc_pkg::STRAP_ALL;
		end
	end

	// floppy low-power latch, set wins over recovery
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flop_low_q <= 1'b0;
			xtal_low_q <= 1'b0;
		end else if (ce) begin
			if (flop_lowpwr) begin
				flop_low_q <= 1'b1;
				xtal_low_q <= xtal_sel;
			end else if (flop_recover) begin
				flop_low_q <= 1'b0;
				xtal_low_q <= 1'b0;
			end
		end
	end

	// settle timer: reloads while the crystal is off
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stab_q <= 32'h0;
		end else if (ce) begin
			if (xtal_off)
				stab_q <= 32'(XTAL_CYCLES);
			else if (!stable)
				stab_q <= stab_q - 32'h1;
		end
	end

	// all pin outputs lag their cause by one enabled edge
	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= bus.rd ? rdata_d : 8'h00;
		end
	end

	// media sense or rate output role
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rate_select_outputs <= 2'h0;
			rate_select_oe      <= 2'h0;
			media_sense_value   <= 2'h0;
		end else if (ce) begin
			rate_select_outputs <= rate_in;
			rate_select_oe <= {2{pinfunc_q[ppc_pkg::PF_RATE]}};
			media_sense_value <= pinfunc_q[ppc_pkg::PF_RATE]
				? 2'h0 : media_sense_inputs;
		end
	end

	// disk dma and drive-mode strap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive_mode_value <= 1'b0;
			disk_dma_enable  <= 1'b0;
		end else if (ce) begin
			disk_dma_enable <= pinfunc_q[ppc_pkg::PF_DMA];
			drive_mode_value <= pinfunc_q[ppc_pkg::PF_DMA]
				|| drive_mode_strap;
		end
	end

	// printer/floppy multiplexor pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			printer_floppy_mux <= 1'b0;
			mux_pins_oe        <= 1'b0;
			mux_pullup_en      <= 1'b0;
		end else if (ce) begin
			printer_floppy_mux <= pinfunc_q[ppc_pkg::PF_MUX];
			mux_pins_oe <= pinfunc_q[ppc_pkg::PF_MUX]
				&& !pinfunc_q[ppc_pkg::PF_FLOAT];
			mux_pullup_en <= !pinfunc_q[ppc_pkg::PF_FLOAT];
		end
	end

	// drive and motor pins after the exchange
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drv_pins <= '0;
		end else if (ce) begin
			drv_pins <= drv_d;
		end
	end

	// shared zero-wait / chip-select pin
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			zero_wait_output   <= 1'b0;
			zero_wait_oe       <= 1'b0;
			chip_select_output <= 1'b0;
			chip_select_oe     <= 1'b0;
		end else if (ce) begin
			zero_wait_output <= 1'b0;         // open drain, enable pulls low
			zero_wait_oe <= !pinfunc_q[ppc_pkg::PF_PDSEL]
				&& pinfunc_q[ppc_pkg::PF_ZWS]
				&& printer_q[ppc_pkg::PR_EN]
				&& epp_short_ok;
			chip_select_output <= chip_sel_in;
			chip_select_oe <= cs_role;
		end
	end

	// ready output or recording-mode strap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chrdy_out            <= 1'b0;
			chrdy_oe             <= 1'b0;
			recording_mode_value <= 1'b0;
		end else if (ce) begin
			chrdy_out <= 1'b0;                // open drain, enable pulls low
			chrdy_oe <= !pinfunc_q[ppc_pkg::PF_RECSEL]
				&& epp_wait;
			recording_mode_value <= pinfunc_q[ppc_pkg::PF_RECSEL]
				&& recording_mode_strap;
		end
	end

	// enhanced printer port controls
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			epp_access_ok  <= 1'b0;
			epp_version_19 <= 1'b0;
			epp_level_irq  <= 1'b0;
		end else if (ce) begin
			epp_access_ok <= printer_q[ppc_pkg::PR_EN]
				&& epp_access;
			epp_version_19 <= printer_q[ppc_pkg::PR_VER];
			epp_level_irq <= printer_q[ppc_pkg::PR_LEVEL];
		end
	end

	// function clocks, crystal and master request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			request_for_master <= 1'b0;
			clk_en             <= '0;
			xtal_run           <= 1'b1;
		end else if (ce) begin
			request_for_master <= rqm_core && stable
				&& !xtal_off && fl_on;
			clk_en.uart1 <= u1_on && !xtal_off;
			clk_en.uart2 <= u2_on && !xtal_off;
			clk_en.flop  <= fl_on && !xtal_off;
			xtal_run <= !xtal_off;
		end
	end

	// read data straight from its flop
	assign rdata = rdata_q;
endmodule

// ### bench/ppc_chk.sv
// checker: port assertions for pin option and power control
module ppc_chk (
	// clock and reset
	input wire logic                clk,
	input wire logic                resetn,
	// pin options
	input wire logic [1:0]          rate_select_oe,
	input wire logic [1:0]          media_sense_value,
	input wire logic                disk_dma_enable,
	input wire logic                drive_mode_value,
	input wire logic                printer_floppy_mux,
	input wire logic                mux_pins_oe,
	input wire logic                mux_pullup_en,
	// shared pins and printer port
	input wire logic                epp_short_ok,
	input wire logic                zero_wait_oe,
	input wire logic                chip_select_oe,
	input wire logic                epp_wait,
	input wire logic                chrdy_oe,
	input wire logic                recording_mode_value,
	input wire logic                epp_access,
	input wire logic                epp_access_ok,
	// clocks and floppy status
	input wire logic                rqm_core,
	input wire logic                request_for_master,
	input wire ppc_pkg::ppc_clken_t clk_en,
	input wire logic                xtal_run
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// pin roles
	a_rate_role: assert property (rate_select_oe != 2'h0
		|-> media_sense_value == 2'h0) else $error("sense and rate both on");
	a_dma_strap: assert property (disk_dma_enable |-> drive_mode_value)
		else $error("dma on with strap low");
	a_mux_drive: assert property (mux_pins_oe
		|-> printer_floppy_mux && mux_pullup_en) else $error("mux pins bad");
	a_zero_wait: assert property (zero_wait_oe
		|-> $past(epp_short_ok) && !chip_select_oe) else $error("zws bad");
	a_ready_pin: assert property (chrdy_oe
		|-> $past(epp_wait) && !recording_mode_value) else $error("rdy bad");
	a_epp_gate: assert property (epp_access_ok |-> $past(epp_access))
		else $error("access passed without request");
	// clocks and crystal
	a_xtal_clks: assert property (!xtal_run |-> clk_en == 3'h0)
		else $error("clock runs with crystal off");
	a_rqm_cause: assert property (request_for_master |-> $past(rqm_core))
		else $error("master request without core");
	a_xtal_settle: assert property ($rose(xtal_run)
		|-> !request_for_master [*8]) else $error("master request too early");
endmodule

bind ppc_top ppc_chk chk_u (.clk, .resetn, .rate_select_oe,
	.media_sense_value, .disk_dma_enable, .drive_mode_value,
	.printer_floppy_mux, .mux_pins_oe, .mux_pullup_en, .epp_short_ok,
	.zero_wait_oe, .chip_select_oe, .epp_wait, .chrdy_oe,
	.recording_mode_value, .epp_access, .epp_access_ok, .rqm_core,
	.request_for_master, .clk_en, .xtal_run);

// ### bench/ppc_top_test.sv
// testbench: register, pin option and power control checks
module ppc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetn, ce, valid_strap_input, drive_mode_strap, rd_q;
	logic epp_short_ok, chip_sel_in, power_down_pin, epp_wait, epp_access;
	logic recording_mode_strap, flop_lowpwr, flop_recover, rqm_core;
	logic disk_dma_enable, drive_mode_value, printer_floppy_mux;
	logic mux_pins_oe, mux_pullup_en, zero_wait_output, zero_wait_oe;
	logic chip_select_output, chip_select_oe, chrdy_out, chrdy_oe;
	logic recording_mode_value, epp_access_ok, epp_version_19;
	logic epp_level_irq, request_for_master, xtal_run;
	logic [1:0] media_sense_inputs, rate_in, rate_select_outputs;
	logic [1:0] rate_select_oe, media_sense_value;
	logic [4:0] configuration_straps;
	logic [7:0] rdata, d, p;
	logic [7:0] exp_q[$];
	logic [1:0] rate_seen;
	logic       cs_seen, zws_seen, wait_seen, acc_seen;
	ppc_pkg::ppc_bus_t   bus;
	ppc_pkg::ppc_drive_t drv_in, drv_pins, sw;
	ppc_pkg::ppc_clken_t clk_en;
	int mismatches, n_compared, i;

	ppc_top #(.XTAL_CYCLES(20)) dut_u (.*);

	// compare and count
	task automatic chk(input logic [7:0] s, input logic [7:0] e,
		input string what);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask
	// one bus cycle, then idle
	task automatic acc(input logic [2:0] a, input logic [7:0] v, input logic w);
		@(posedge clk) bus <= '{a, v, w, !w};
		@(posedge clk) bus <= '0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(a, 8'h00, 1'b0);
	endtask
	task automatic st;
		repeat (3) @(negedge clk);
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// clock
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// read data checked the cycle after the strobe
	always @(posedge clk) rd_q <= bus.rd;
	always @(negedge clk) if (rd_q) chk(rdata, exp_q.pop_front(), "rdata");
	// random host-side activity
	always @(posedge clk) begin
		{epp_short_ok, epp_wait, epp_access, rqm_core} <= 4'($urandom);
		{chip_sel_in, rate_in} <= 3'($urandom);
		// inputs as the design sampled them at this edge
		{rate_seen, cs_seen} <= {rate_in, chip_sel_in};
		{zws_seen, wait_seen, acc_seen} <= {epp_short_ok, epp_wait, epp_access};
	end
	// hang guard
	initial begin
		#400000;
		mismatches++;
		results();
	end

	// main sequence
	initial begin
		{resetn, bus, drive_mode_strap, recording_mode_strap, drv_in} = '0;
		{flop_lowpwr, flop_recover, configuration_straps} = '0;
		media_sense_inputs = 2'h0;
		{ce, valid_strap_input, power_down_pin} = 3'h7;
		void'($urandom(11));
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(3'h3, 8'h01);
		rd(3'h4, ppc_pkg::PRINTER_RST);
		rd(3'h0, ppc_pkg::FEATURE_RST);
		rd(3'h1, 8'h00);
		rd(3'h7, 8'h00);
		$display("test 1 done");
		for (i = 0; i < 8; i++) begin
			{media_sense_inputs, drv_in, recording_mode_strap, drive_mode_strap}
				<= 8'($urandom);
			d = 8'($urandom);
			p = 8'($urandom);
			acc(3'h3, d, 1'b1);
			acc(3'h4, p, 1'b1);
			st();
			sw = d[4] ? {drv_in.sel1, drv_in.sel0, drv_in.mot1, drv_in.mot0}
				: drv_in;
			chk(rate_select_oe, {2{d[0]}}, "rate_oe");
			chk(media_sense_value, d[0] ? 2'h0 : media_sense_inputs, "ms");
			chk(drive_mode_value, drive_mode_strap | d[1], "strap");
			chk(disk_dma_enable, d[1], "dma");
			chk(printer_floppy_mux, d[2], "mux");
			chk(mux_pins_oe, d[2] & !d[3], "mux_oe");
			chk(mux_pullup_en, !d[3], "pullup");
			chk(drv_pins, sw, "drive");
			chk(recording_mode_value, d[7] & recording_mode_strap, "rec");
			chk(epp_version_19, p[1], "ver");
			chk(epp_level_irq, p[4], "irq");
			chk(rate_select_outputs, rate_seen, "rate");
			chk(chip_select_output, cs_seen, "cs");
			chk(zero_wait_output, 1'b0, "zws");
			chk(zero_wait_oe, !d[6] & d[5] & p[0] & zws_seen, "zws_oe");
			chk(chrdy_out, 1'b0, "rdy");
			chk(chrdy_oe, !d[7] & wait_seen, "rdy_oe");
			chk(epp_access_ok, p[0] & acc_seen, "epp_ok");
			rd(3'h3, d);
			rd(3'h4, p & ppc_pkg::PR_WMASK);
		end
		$display("test 2 done");
		acc(3'h3, 8'h40, 1'b1);
		acc(3'h2, 8'h01, 1'b1);
		st();
		chk(clk_en, 3'h0, "pd");
		chk(xtal_run, 1'b1, "xtal");
		acc(3'h2, 8'h00, 1'b1);
		acc(3'h0, 8'h0C, 1'b1);
		st();
		chk(clk_en, 3'h3, "disabled");
		acc(3'h0, 8'h0E, 1'b1);
		@(posedge clk) power_down_pin <= 1'b0;
		st();
		chk(clk_en, 3'h0, "pin_pd");
		@(posedge clk) power_down_pin <= 1'b1;
		st();
		chk(clk_en, 3'h7, "restore");
		acc(3'h2, 8'h04, 1'b1);
		st();
		chk(chip_select_oe, 1'b1, "cs_oe");
		@(posedge clk) flop_lowpwr <= 1'b1;
		@(posedge clk) flop_lowpwr <= 1'b0;
		st();
		chk(clk_en, 3'h6, "flop_low");
		@(posedge clk) flop_recover <= 1'b1;
		@(posedge clk) flop_recover <= 1'b0;
		st();
		chk(clk_en, 3'h7, "flop_back");
		$display("test 3 done");
		acc(3'h2, 8'h03, 1'b1);
		st();
		chk(xtal_run, 1'b0, "xtal_off");
		acc(3'h2, 8'h00, 1'b1);
		st();
		chk(request_for_master, 1'b0, "rqm_hold");
		for (i = 0; i < 100 && request_for_master !== 1'b1; i++) @(negedge clk);
		chk(request_for_master, 1'b1, "rqm");
		chk(8'(i > 12), 8'h01, "settle");
		$display("test 4 done");
		@(posedge clk) begin
			resetn <= 1'b0;
			configuration_straps <= ppc_pkg::STRAP_ALL;
			valid_strap_input <= 1'b0;
		end
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		st();
		chk(xtal_run, 1'b0, "strap_xtal");
		rd(3'h3, 8'h00);
		st();
		$display("test 5 done");
		results();
	end
endmodule
